// >>> irq_regs_map.svh
// Register offsets, field positions, reset values and widths of the interrupt enable and priority block.
`ifndef IRQ_REGS_MAP_SVH
`define IRQ_REGS_MAP_SVH

`define ADDR_W 4
`define DATA_W 16

`define OFS_ENABLE_3 4'h0
`define OFS_ENABLE_4 4'h1
`define OFS_PRIORITY_0 4'h2
`define OFS_PRIORITY_1 4'h3
`define OFS_PRIORITY_2 4'h4
`define OFS_PRIORITY_3 4'h5
`define OFS_FLAGS_3 4'h6
`define OFS_FLAGS_4 4'h7

`define EN3_PWM_A_FAULT 15
`define EN3_ENCODER_EVENT 10
`define EN3_PWM_A_ERROR 9
`define EN4_PWM_B_FAULT 10
`define EN4_PWM_B_ERROR 9
`define EN4_SERIAL_ERROR 1

`define EN3_MASK 16'h8600
`define EN4_MASK 16'h0602
`define PRI0_MASK 16'h7777
`define PRI1_MASK 16'h7770
`define PRI2_MASK 16'h7777
`define PRI3_MASK 16'h0077

`define ENABLE_RESET 16'h0000
`define PRI0_RESET 16'h4444
`define PRI1_RESET 16'h4440
`define PRI2_RESET 16'h4444
`define PRI3_RESET 16'h0044

`define NUM_EN_SRC 6
`define NUM_PRI_SRC 14

`endif

// >>> irq_regs_pkg.sv
// Types shared by the interrupt enable and priority block.
package irq_regs_pkg;
    typedef logic [2:0] prio_type;
    typedef logic [15:0] word_type;
    typedef enum {ACC_IDLE, ACC_READ_DONE} access_type;
endpackage

// >>> irq_gate.sv
// One source's request gate: flag, enable and priority combined into a registered request.
`timescale 1ns/10ps
module irq_gate
    import irq_regs_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Source state.
    input wire logic flag_i,
    input wire logic enable_i,
    input wire irq_regs_pkg::prio_type prio_i,
    // Offered request.
    output logic req_o,
    output irq_regs_pkg::prio_type level_o
);
    // The level offered equals the field's binary value; zero keeps the source silent.
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            req_o <= 1'b0;
            level_o <= 3'h0;
        end
        else
        begin
            req_o <= flag_i && enable_i && (prio_i != 3'h0);
            level_o <= prio_i;
        end
    end

    a_gate_blocked: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (prio_i == 3'h0 || !enable_i) |=> !req_o)
        else $error("Request offered from a disabled source.");
endmodule

// >>> irq_enable_priority_regs.sv
// Interrupt enable and priority registers with flag capture and request gating.
// What this block does
// - Enable bit one passes, zero blocks request.
// - Enable bits read, write, reset zero.
// - Unimplemented bits always read zero.
// - Priority fields three bits; 111 level seven.
// - Code 001 level one; binary value level.
// - Priority 000 disables source entirely.
// - Enable three: bits 15, 10, 9.
// - Enable four: bits 10, 9, 1.
// - Priority zero: four fields at documented positions.
// - Priority one: three fields, low nibble unused.
// - Priority two: four fields at documented positions.
// - Priority three: bits 6-4 and 2-0.
// - Flag reads one after request occurred.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "irq_regs_map.svh"
module irq_enable_priority_regs
    import irq_regs_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Register port.
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire irq_regs_pkg::word_type wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output irq_regs_pkg::word_type rdata_o,
    // Peripheral request pulses: enable-register sources, then priority-register sources.
    input wire logic [`NUM_EN_SRC-1:0] en_src_req_i,
    input wire logic [`NUM_PRI_SRC-1:0] pri_src_req_i,
    // Per-source enable bits for the flags held elsewhere.
    output logic [`NUM_PRI_SRC-1:0] pri_src_enable_o,
    // Offered requests and their levels.
    output logic [`NUM_EN_SRC-1:0] en_src_irq_o,
    output logic [`NUM_PRI_SRC-1:0] pri_src_prio_nz_o,
    output logic [3*`NUM_PRI_SRC-1:0] pri_src_level_o
);
    import irq_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage.

    word_type enable_3;
    word_type enable_4;
    word_type priority_0;
    word_type priority_1;
    word_type priority_2;
    word_type priority_3;
    logic [`NUM_EN_SRC-1:0] flag;
    word_type next_rdata;
    logic [`NUM_EN_SRC-1:0] en_bits;
    logic [`NUM_EN_SRC-1:0] flag_clr;
    logic [`NUM_EN_SRC-1:0] gate_req;
    prio_type en_src_prio [`NUM_EN_SRC];
    logic [3*`NUM_PRI_SRC-1:0] all_levels;
    access_type acc_state;

    // Reads one three-bit field at a given low bit.
    function automatic prio_type field_at(input word_type w, input int lsb);
        field_at = 3'(w >> lsb);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Enable register writes; masking keeps unimplemented bits at zero.

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            enable_3 <= `ENABLE_RESET;
            enable_4 <= `ENABLE_RESET;
        end
        else if (wr_i)
        begin
            if (addr_i == `OFS_ENABLE_3)
            begin
                enable_3 <= wdata_i & `EN3_MASK;
            end
            if (addr_i == `OFS_ENABLE_4)
            begin
                enable_4 <= wdata_i & `EN4_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Priority register writes; each field resets to mid level four.

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            priority_0 <= `PRI0_RESET;
            priority_1 <= `PRI1_RESET;
            priority_2 <= `PRI2_RESET;
            priority_3 <= `PRI3_RESET;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `OFS_PRIORITY_0: priority_0 <= wdata_i & `PRI0_MASK;
                `OFS_PRIORITY_1: priority_1 <= wdata_i & `PRI1_MASK;
                `OFS_PRIORITY_2: priority_2 <= wdata_i & `PRI2_MASK;
                `OFS_PRIORITY_3: priority_3 <= wdata_i & `PRI3_MASK;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags for the six enable-register sources; a request in the clearing cycle wins.

    assign en_bits = {enable_3[`EN3_PWM_A_FAULT], enable_3[`EN3_ENCODER_EVENT], enable_3[`EN3_PWM_A_ERROR],
                      enable_4[`EN4_PWM_B_FAULT], enable_4[`EN4_PWM_B_ERROR], enable_4[`EN4_SERIAL_ERROR]};

    // Software writes zero to clear a flag; writing one has no effect.
    always_comb
    begin
        flag_clr = '0;
        if (wr_i && addr_i == `OFS_FLAGS_3)
        begin
            flag_clr[5:3] = ~{wdata_i[`EN3_PWM_A_FAULT], wdata_i[`EN3_ENCODER_EVENT], wdata_i[`EN3_PWM_A_ERROR]};
        end
        if (wr_i && addr_i == `OFS_FLAGS_4)
        begin
            flag_clr[2:0] = ~{wdata_i[`EN4_PWM_B_FAULT], wdata_i[`EN4_PWM_B_ERROR], wdata_i[`EN4_SERIAL_ERROR]};
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            flag <= '0;
        end
        else
        begin
            flag <= en_src_req_i | (flag & ~flag_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Gating. These six sources keep their priority fields elsewhere, so a fixed
    // nonzero level stands in for them here.

    generate
        for (genvar g = 0; g < `NUM_EN_SRC; g++)
        begin : gen_gate
            assign en_src_prio[g] = 3'h4;
            irq_gate u_gate (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .flag_i(flag[g]),
                .enable_i(en_bits[g]),
                .prio_i(en_src_prio[g]),
                .req_o(gate_req[g]),
                .level_o()
            );
        end
    endgenerate

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            en_src_irq_o <= '0;
        end
        else
        begin
            en_src_irq_o <= gate_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Priority field outputs for the fourteen prioritised sources, order timer_a first.

    assign all_levels = {field_at(priority_0, 12), field_at(priority_0, 8), field_at(priority_0, 4),
                         field_at(priority_0, 0), field_at(priority_1, 12), field_at(priority_1, 8),
                         field_at(priority_1, 4), field_at(priority_2, 12), field_at(priority_2, 8),
                         field_at(priority_2, 4), field_at(priority_2, 0), field_at(priority_3, 4),
                         field_at(priority_3, 0), 3'h0};

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            pri_src_level_o <= '0;
            pri_src_prio_nz_o <= '0;
            pri_src_enable_o <= '0;
        end
        else
        begin
            pri_src_level_o <= {all_levels[3*`NUM_PRI_SRC-1:3], 3'h0};
            for (int i = 0; i < `NUM_PRI_SRC; i++)
            begin
                pri_src_prio_nz_o[i] <= (all_levels[3*i +: 3] != 3'h0) && pri_src_req_i[i];
                pri_src_enable_o[i] <= (all_levels[3*i +: 3] != 3'h0);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path: data stand one cycle after the strobe; unmapped reads give zero.

    always_comb
    begin
        case (addr_i)
            `OFS_ENABLE_3: next_rdata = enable_3 & `EN3_MASK;
            `OFS_ENABLE_4: next_rdata = enable_4 & `EN4_MASK;
            `OFS_PRIORITY_0: next_rdata = priority_0 & `PRI0_MASK;
            `OFS_PRIORITY_1: next_rdata = priority_1 & `PRI1_MASK;
            `OFS_PRIORITY_2: next_rdata = priority_2 & `PRI2_MASK;
            `OFS_PRIORITY_3: next_rdata = priority_3 & `PRI3_MASK;
            `OFS_FLAGS_3: next_rdata = {flag[5], 4'h0, flag[4], flag[3], 9'h000};
            `OFS_FLAGS_4: next_rdata = {5'h00, flag[2], flag[1], 7'h00, flag[0], 1'b0};
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            rdata_o <= 16'h0000;
            acc_state <= ACC_IDLE;
        end
        else
        begin
            rdata_o <= rd_i ? next_rdata : 16'h0000;
            case (acc_state)
                ACC_IDLE: acc_state <= rd_i ? ACC_READ_DONE : ACC_IDLE;
                ACC_READ_DONE: acc_state <= rd_i ? ACC_READ_DONE : ACC_IDLE;
                default: acc_state <= ACC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    // Unimplemented enable bits can never be stored.
    a_enable_reserved_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ((enable_3 & ~`EN3_MASK) == 16'h0000) && ((enable_4 & ~`EN4_MASK) == 16'h0000))
        else $error("Unimplemented enable bit is set.");
    // A write to enable register 3 lands on the next edge.
    a_enable_write_lands: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_i && addr_i == `OFS_ENABLE_3 |=> enable_3 == ($past(wdata_i) & `EN3_MASK))
        else $error("Enable register 3 write did not land.");
    // A write to enable register 4 lands on the next edge.
    a_enable4_write_lands: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_i && addr_i == `OFS_ENABLE_4 |=> enable_4 == ($past(wdata_i) & `EN4_MASK))
        else $error("Enable register 4 write did not land.");
    // Priority register 3 keeps its upper bits and bit 3 clear on reads.
    a_prio3_reserved: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_i && addr_i == `OFS_PRIORITY_3 |=> rdata_o[15:7] == 9'h000 && rdata_o[3] == 1'b0)
        else $error("Reserved priority bits read nonzero.");
    // Priority register 1 has no field in its low nibble.
    a_prio1_low_nibble: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_i && addr_i == `OFS_PRIORITY_1 |=> rdata_o[3:0] == 4'h0)
        else $error("Priority register 1 low nibble reads nonzero.");
    // Priority register 0 reads back what it holds.
    a_read_returns: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_i && addr_i == `OFS_PRIORITY_0 && !$past(wr_i) |=> rdata_o == $past(priority_0))
        else $error("Priority register 0 read mismatch.");
    // A request always sets its flag, even against a clearing write.
    a_flag_set_wins: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        en_src_req_i[0] |=> flag[0])
        else $error("Request lost against flag clear.");
    // Source 5, disabled for two cycles running, is not offered in the cycle after.
    a_irq_needs_enable: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !en_bits[5] ##1 !en_bits[5] |=> !en_src_irq_o[5])
        else $error("Disabled source offered.");
    // A write to priority register 2 lands on the next edge.
    a_prio2_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_i && addr_i == `OFS_PRIORITY_2 |=> priority_2 == ($past(wdata_i) & `PRI2_MASK))
        else $error("Priority register 2 write did not land.");
    // Read data stand only in cycles that follow a strobe cycle, so a slow poller cannot see stale values.
    a_read_stands_once: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        acc_state == ACC_IDLE |-> rdata_o == 16'h0000)
        else $error("Read data stood outside the cycle after the strobe.");
    // The first cycle after reset shows every enable bit cleared.
    a_enable_reset_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $past(sys_rst_i) |-> enable_3 == `ENABLE_RESET && enable_4 == `ENABLE_RESET)
        else $error("Enable bits not cleared by reset.");
    // Every implemented priority field leaves reset at mid level four.
    a_prio_reset_mid: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $past(sys_rst_i) |-> priority_0 == `PRI0_RESET && priority_1 == `PRI1_RESET &&
        priority_2 == `PRI2_RESET && priority_3 == `PRI3_RESET)
        else $error("Priority fields not at default after reset.");
    // Enable register 3 reads back what it holds.
    a_enable3_readback: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_i && addr_i == `OFS_ENABLE_3 |=> rdata_o == $past(enable_3))
        else $error("Enable register 3 read mismatch.");
    // Masking leaves every unimplemented priority bit clear.
    a_prio_reserved_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ((priority_0 & ~`PRI0_MASK) == 16'h0000) && ((priority_1 & ~`PRI1_MASK) == 16'h0000) &&
        ((priority_2 & ~`PRI2_MASK) == 16'h0000) && ((priority_3 & ~`PRI3_MASK) == 16'h0000))
        else $error("Unimplemented priority bit is set.");
    // Indices beyond the flag registers read as zero.
    a_unmapped_read_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_i && addr_i > `OFS_FLAGS_4 |=> rdata_o == 16'h0000)
        else $error("Unmapped index read nonzero.");
    // Flag reads keep every bit outside the six sources clear.
    a_flag_reserved_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_i && (addr_i == `OFS_FLAGS_3 || addr_i == `OFS_FLAGS_4) |=>
        (rdata_o & ~(`EN3_MASK | `EN4_MASK)) == 16'h0000)
        else $error("Unimplemented flag bit read nonzero.");
    // A write to priority register 0 lands on the next edge.
    a_prio0_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_i && addr_i == `OFS_PRIORITY_0 |=> priority_0 == ($past(wdata_i) & `PRI0_MASK))
        else $error("Priority register 0 write did not land.");
    // A write to priority register 1 lands on the next edge.
    a_prio1_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_i && addr_i == `OFS_PRIORITY_1 |=> priority_1 == ($past(wdata_i) & `PRI1_MASK))
        else $error("Priority register 1 write did not land.");
    // A write to priority register 3 lands on the next edge.
    a_prio3_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_i && addr_i == `OFS_PRIORITY_3 |=> priority_3 == ($past(wdata_i) & `PRI3_MASK))
        else $error("Priority register 3 write did not land.");
    // Code 111 comes out as level seven.
    a_top_level_seven: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        priority_0[14:12] == 3'h7 |=> pri_src_level_o[41:39] == 3'h7)
        else $error("Code 111 not offered as level seven.");
    // Code 001 comes out as level one.
    a_level_one: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        priority_0[10:8] == 3'h1 |=> pri_src_level_o[38:36] == 3'h1)
        else $error("Code 001 not offered as level one.");
    // A zero field silences its source whatever it requests.
    a_zero_prio_silent: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        priority_0[6:4] == 3'h0 |=> !pri_src_prio_nz_o[11] && !pri_src_enable_o[11])
        else $error("Source with zero priority offered.");
    // A requesting source with a nonzero field is offered.
    a_offer_follows_req: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        pri_src_req_i[13] && priority_0[14:12] != 3'h0 |=> pri_src_prio_nz_o[13])
        else $error("Valid request not offered.");
    // A set flag with its enable reaches the output after the gate and output stages.
    a_en_irq_offered: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        flag[5] && en_bits[5] |-> ##2 en_src_irq_o[5])
        else $error("Enabled pending source not offered.");
    // Writing zero to a flag clears it when no request competes.
    a_flag_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        wr_i && addr_i == `OFS_FLAGS_3 && !wdata_i[`EN3_PWM_A_FAULT] && !en_src_req_i[5] |=> !flag[5])
        else $error("Flag not cleared by a zero write.");
    // A flag stays set until software writes its register.
    a_flag_holds: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        flag[5] && !(wr_i && addr_i == `OFS_FLAGS_3) |=> flag[5])
        else $error("Flag dropped without a clearing write.");
    // A set flag reads as one at its position.
    a_flag3_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rd_i && addr_i == `OFS_FLAGS_3 && flag[5] |=> rdata_o[`EN3_PWM_A_FAULT])
        else $error("Set flag read as zero.");
endmodule

// >>> irq_core_model.sv
// Behavioural model of the core that arbitrates the offered interrupt requests.
`timescale 1ns/10ps
module irq_core_model
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Offered requests and levels.
    input wire logic [5:0] en_src_irq_i,
    input wire logic [13:0] pri_src_prio_nz_i,
    input wire logic [41:0] pri_src_level_i,
    // Accepted request.
    output logic take_o,
    output logic [4:0] winner_o,
    output logic [2:0] level_o
);
    logic [2:0] best;
    logic [4:0] who;

    ////////////////////////////////////////////////////////////////////////////
    // Highest offered level wins; a tie goes to the higher index among 1 to 13, else to the lower index. A level of zero never wins.
    always_comb
    begin
        best = 3'h0;
        who = 5'h00;
        for (int i = 13; i >= 1; i--)
            if (pri_src_prio_nz_i[i] && pri_src_level_i[3*i +: 3] > best)
            begin
                best = pri_src_level_i[3*i +: 3];
                who = 5'(i);
            end
        // The enable-register sources sit at the fixed level 4, numbered from 14 up.
        for (int k = 0; k < 6; k++)
            if (en_src_irq_i[k] && best < 3'h4)
            begin
                best = 3'h4;
                who = 5'(14 + k);
            end
    end

    // The decision is registered, as a real core would take it on an edge.
    always_ff @(posedge mclk_i)
    begin
        take_o <= !sys_rst_i && best != 3'h0;
        winner_o <= who;
        level_o <= best;
    end
endmodule

// >>> tb.sv
// Self-checking testbench for the interrupt enable and priority registers.
`timescale 1ns/10ps
`include "irq_regs_map.svh"
module tb;
    import irq_regs_pkg::*;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [`ADDR_W-1:0] addr_i = 4'h0;
    word_type wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    word_type rdata_o;
    logic [`NUM_EN_SRC-1:0] en_src_req_i = 6'h00;
    logic [`NUM_PRI_SRC-1:0] pri_src_req_i = 14'h0000;
    logic [`NUM_PRI_SRC-1:0] pri_src_enable_o;
    logic [`NUM_EN_SRC-1:0] en_src_irq_o;
    logic [`NUM_PRI_SRC-1:0] pri_src_prio_nz_o;
    logic [3*`NUM_PRI_SRC-1:0] pri_src_level_o;
    logic take;
    logic [4:0] winner;
    logic [2:0] win_level;
    int n_errors = 0;
    int num_checks = 0;
    word_type rd_val;
    // Rows: index, value after reset, value after writing all ones.
    logic [3:0] r_addr [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
    word_type r_rst [7] = '{16'h0000, 16'h0000, 16'h4444, 16'h4440, 16'h4444, 16'h0044, 16'h0000};
    word_type r_all [7] = '{16'h8600, 16'h0602, 16'h7777, 16'h7770, 16'h7777, 16'h0077, 16'h0000};

    irq_enable_priority_regs i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .en_src_req_i(en_src_req_i), .pri_src_req_i(pri_src_req_i),
        .pri_src_enable_o(pri_src_enable_o), .en_src_irq_o(en_src_irq_o), .pri_src_prio_nz_o(pri_src_prio_nz_o),
        .pri_src_level_o(pri_src_level_o));
    irq_core_model i_core (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .en_src_irq_i(en_src_irq_o),
        .pri_src_prio_nz_i(pri_src_prio_nz_o), .pri_src_level_i(pri_src_level_o), .take_o(take),
        .winner_o(winner), .level_o(win_level));

    ////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock.
    always #50 mclk_i = ~mclk_i;

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe; the strobe drops one edge later so a following access never overlaps it.
    task automatic reg_write(input logic [3:0] a, input word_type d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic reg_read(input logic [3:0] a, output word_type d);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole sequence needs about 140 cycles.
    initial
    begin
        #(100 * 3000);
        n_errors++;
        wrap_up();
    end

    initial
    begin
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        // Table rows: reset value, implemented bits of all ones, then back to zero.
        for (int i = 0; i < 7; i++)
        begin
            reg_read(r_addr[i], rd_val);
            check(rd_val, r_rst[i]);
            reg_write(r_addr[i], 16'hffff);
            reg_read(r_addr[i], rd_val);
            check(rd_val, r_all[i]);
            reg_write(r_addr[i], 16'h0000);
            reg_read(r_addr[i], rd_val);
            check(rd_val, 16'h0000);
        end
        $display("Register table test finished.");
        // Requests while disabled are flagged but not offered.
        @(posedge mclk_i);
        en_src_req_i <= 6'h3f;
        @(posedge mclk_i);
        en_src_req_i <= 6'h00;
        repeat (3) @(posedge mclk_i);
        #1 check(en_src_irq_o, 6'h00);
        reg_read(4'h6, rd_val);
        check(rd_val, 16'h8600);
        @(posedge mclk_i);
        #1 check(rdata_o, 16'h0000);
        reg_read(4'h7, rd_val);
        check(rd_val, 16'h0602);
        reg_write(4'h0, 16'h8600);
        reg_write(4'h1, 16'h0602);
        repeat (3) @(posedge mclk_i);
        #1 check(en_src_irq_o, 6'h3f);
        reg_write(4'h1, 16'h0000);
        repeat (3) @(posedge mclk_i);
        #1 check(en_src_irq_o, 6'h38);
        reg_write(4'h6, 16'h0000);
        repeat (3) @(posedge mclk_i);
        #1 check(en_src_irq_o, 6'h00);
        $display("Enable and flag test finished.");
        // Levels 7, 1, 0, 3 in the first priority register, level 2 for the converter.
        reg_write(4'h2, 16'h7103);
        reg_write(4'h5, 16'h0020);
        @(posedge mclk_i);
        pri_src_req_i <= 14'h3ffe;
        repeat (3) @(posedge mclk_i);
        #1 check(pri_src_level_o[41:30], 12'he43);
        check(pri_src_level_o[8:0], 9'h080);
        check(pri_src_prio_nz_o, 14'h3404);
        check(pri_src_enable_o, 14'h3404);
        check({take, winner, win_level}, {1'b1, 5'h0d, 3'h7});
        @(posedge mclk_i);
        pri_src_req_i <= 14'h0000;
        repeat (3) @(posedge mclk_i);
        #1 check({pri_src_prio_nz_o, take}, 15'h0000);
        $display("Priority test finished.");
        // A request in the very cycle of its clearing write must win.
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= 4'h7;
        wdata_i <= 16'h0000;
        en_src_req_i <= 6'h01;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        en_src_req_i <= 6'h00;
        reg_read(4'h7, rd_val);
        check(rd_val, 16'h0002);
        // Mid-run reset: outputs clear during it, defaults show one edge after release.
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1 check({en_src_irq_o, pri_src_enable_o, pri_src_prio_nz_o, take}, 35'h0);
        check(pri_src_level_o, 42'h0);
        @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        #1 check(pri_src_enable_o, 14'h3ffe);
        check(pri_src_level_o, 42'h24924924920);
        reg_read(4'h0, rd_val);
        check(rd_val, 16'h0000);
        reg_read(4'h6, rd_val);
        check(rd_val, 16'h0000);
        reg_read(4'h2, rd_val);
        check(rd_val, 16'h4444);
        $display("Reset and set-wins test finished.");
        wrap_up();
    end
endmodule
